//--- verilog/bpc_pkg.sv
/*
  Package for the bidirectional port with change interrupt: register
  offsets, field positions, reset values and write-operation codes.
  Assumes an 8-bit register address and 8-bit data on a plain strobe port.
*/
// Function
// - Eight pins, each with own direction bit
// - Direction one floats pin, zero drives latch
// - Data read returns pins; write updates latch
// - Set and clear writes sample pins, modify, store all bits
// - Option bit seven low enables all pull-ups
// - Output pins never get a pull-up
// - Pull-ups are off after reset
// - Only upper input pins join change compare
// - Mismatch versus last-access reference sets change flag
// - Change event wakes the device from sleep
// - Any data access refreshes the comparison reference
// - Mismatch keeps setting flag; clear after access
// - Change during a read may be missed
// - Pin zero feeds external interrupt, Schmitt in that mode
// - Pin six is programming clock, Schmitt then
// - Pin seven is programming data, Schmitt then
// - Direction and option reset to all ones
package bpc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_IO_DATA      = 8'h06;
  localparam logic [7:0] OFS_CONFIG_OPT   = 8'h81;
  localparam logic [7:0] OFS_IO_DIRECTION = 8'h86;
  localparam logic [7:0] OFS_IRQ_CONTROL  = 8'h0B;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h8B;
  localparam logic [7:0] OFS_IO_SET       = 8'h16;
  localparam logic [7:0] OFS_IO_CLR       = 8'h26;

  // Field positions
  localparam int unsigned OPT_PULLUP_N_BIT = 7;
  localparam int unsigned IRQ_CHANGE_BIT   = 0;
  localparam int unsigned EXT_IRQ_PIN      = 0;
  localparam int unsigned PROG_CLK_PIN     = 6;
  localparam int unsigned PROG_DATA_PIN    = 7;
  localparam int unsigned CHG_LO_PIN       = 4;
  localparam int unsigned CHG_W            = 4;

  // Reset values
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_OPTION    = 8'hFF;
  localparam logic [7:0] RST_LATCH     = 8'h00;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // Kind of write to the output latch
  typedef enum logic [1:0] {
    WOP_NONE,
    WOP_LOAD,
    WOP_SET,
    WOP_CLR
  } bpc_wop_t;

endpackage

//--- verilog/bpc_if.sv
/*
  Interfaces between the port top and its change detector and interrupt
  register. Assumes one clock shared by all ends.
*/
`timescale 1ns/100ps
interface bpc_chg_if;
  logic [3:0] pins;
  logic [3:0] dir;
  logic       refresh;
  logic       mismatch;
  modport top (output pins, output dir, output refresh, input mismatch);
  modport det (input pins, input dir, input refresh, output mismatch);
endinterface

interface bpc_irq_if;
  logic       event_set;
  logic       wr_ctl;
  logic       wr_mask;
  logic [7:0] wdata;
  logic [7:0] status;
  logic [7:0] mask;
  logic       irq;
  modport top (output event_set, output wr_ctl, output wr_mask, output wdata,
               input status, input mask, input irq);
  modport irq_reg (input event_set, input wr_ctl, input wr_mask, input wdata,
                   output status, output mask, output irq);
endinterface

//--- verilog/bpc_change_det.sv
/*
  Change detector for the upper four pins against a reference taken at the
  last port access. Assumes pins are synchronous to the clock.
*/
`timescale 1ns/100ps
module bpc_change_det
  import bpc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Detector side
  bpc_chg_if.det    chg
);

  logic [3:0] ref_q;
  logic       mismatch_q;

  // Reference captured on every port access; a change in that cycle lands in it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_q <= 4'h0;
    end else if (chg.refresh) begin
      ref_q <= chg.pins;
    end
  end

  // Mismatch of input pins only, ended by the access itself
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mismatch_q <= 1'b0;
    end else if (chg.refresh) begin
      mismatch_q <= 1'b0;
    end else begin
      mismatch_q <= |((chg.pins ^ ref_q) & chg.dir);
    end
  end

  assign chg.mismatch = mismatch_q;

endmodule

//--- verilog/bpc_irq_reg.sv
/*
  Sticky interrupt status with write-one-to-clear, a mask of the same layout
  and one level interrupt. Assumes one clock and single-cycle write strobes.
*/
`timescale 1ns/100ps
module bpc_irq_reg
  import bpc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Register side
  bpc_irq_if.irq_reg irqc
);

  logic status_q;
  logic mask_q;
  logic irq_q;

  // Flag set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_q <= 1'b0;
    end else if (irqc.event_set) begin
      status_q <= 1'b1;
    end else if (irqc.wr_ctl && irqc.wdata[IRQ_CHANGE_BIT]) begin
      status_q <= 1'b0;
    end
  end

  // Enable mask
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= 1'b0;
    end else if (irqc.wr_mask) begin
      mask_q <= irqc.wdata[IRQ_CHANGE_BIT];
    end
  end

  // Level interrupt from the set and enabled flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= status_q & mask_q;
    end
  end

  assign irqc.status = {7'h00, status_q};
  assign irqc.mask   = {7'h00, mask_q};
  assign irqc.irq    = irq_q;

endmodule

//--- verilog/bpc_port_top.sv
/*
  Eight-bit bidirectional port with per-pin direction, output latch written
  by read-modify-write, global weak pull-up control and change interrupt on
  the upper four pins with wake from sleep.
  Assumes a register master on a plain strobe port, read data one cycle
  after the read strobe, and pin levels synchronous to ref_clk_i. The pad
  ring resolves the wire from pin_o and pin_oe_n_o and applies pull-ups.
  Writes to the set and clear aliases act on the sampled pin levels, so an
  input pin's level lands in its latch bit and shows once the pin turns to
  an output. A plain data write loads the latch as written.
  A pin that moves in the same cycle as a port access becomes the new
  reference and raises no change; keypads should be read only on a change.
  Direction and option reset to all ones, so every pin starts as an input
  with its pull-up off; the latch resets to zero.
  Pull-ups follow the direction and option writes at the same edge.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
module bpc_port_top
  import bpc_pkg::*;
#(
  parameter int unsigned PINS = 8
)
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Port pins
  input  wire logic [PINS-1:0]   pin_i,
  // Pad controls
  output logic      [PINS-1:0]   pin_o,
  output logic      [PINS-1:0]   pin_oe_n_o,
  output logic      [PINS-1:0]   pullup_en_o,
  output logic      [PINS-1:0]   schmitt_sel_o,
  // Mode inputs
  input  wire logic              sleep_i,
  input  wire logic              ext_irq_mode_i,
  input  wire logic              prog_mode_i,
  // Alternate functions
  output logic                   pin0_ext_irq_o,
  output logic                   prog_clk_o,
  output logic                   prog_data_o,
  // Events
  output logic                   wake_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Decode the kind of latch write from the address
  function automatic bpc_wop_t wop_decode(input logic            wr,
                                          input logic [ADDR_W-1:0] addr);
    bpc_wop_t op;
    op = WOP_NONE;
    if (wr) begin
      case (addr)
        OFS_IO_DATA: op = WOP_LOAD;
        OFS_IO_SET:  op = WOP_SET;
        OFS_IO_CLR:  op = WOP_CLR;
        default:     op = WOP_NONE;
      endcase
    end
    return op;
  endfunction

  // Apply an operation to the sampled pin levels
  function automatic logic [PINS-1:0] rmw_apply(input bpc_wop_t        op,
                                                input logic [PINS-1:0] pins,
                                                input logic [PINS-1:0] wd,
                                                input logic [PINS-1:0] latch);
    logic [PINS-1:0] res;
    res = latch;
    case (op)
      WOP_LOAD: res = wd;
      WOP_SET:  res = pins | wd;
      WOP_CLR:  res = pins & ~wd;
      default:  res = latch;
    endcase
    return res;
  endfunction

  // Strobe aimed at one register offset
  function automatic logic reg_hit(input logic              strobe,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  // Widen a pin-wide value to the register width
  function automatic logic [DATA_W-1:0] to_reg(input logic [PINS-1:0] v);
    return DATA_W'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Port registers
  logic [PINS-1:0]   latch_q;
  logic [PINS-1:0]   dir_q;
  logic [PINS-1:0]   dir_d;
  logic [DATA_W-1:0] option_q;
  logic [DATA_W-1:0] option_d;
  logic [DATA_W-1:0] rdata_q;

  // Pad controls
  logic [PINS-1:0]   pin_out_q;
  logic [PINS-1:0]   oe_n_q;
  logic [PINS-1:0]   pullup_q;
  logic [PINS-1:0]   schmitt_q;

  // Alternate functions and events
  logic              ext_irq_q;
  logic              prog_clk_q;
  logic              prog_data_q;
  logic              wake_q;
  logic              init_q;

  // Decoded strobes
  bpc_wop_t          wop;
  logic              data_access;
  logic              rd_data;
  logic              wr_dir;
  logic              wr_opt;
  logic [PINS-1:0]   wdata_p;

  // Links to the change detector and the interrupt register
  bpc_chg_if chg ();
  bpc_irq_if irqc ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Strobe qualification per register
  assign wop         = wop_decode(reg_wr_i, reg_addr_i);
  assign rd_data     = reg_hit(reg_rd_i, reg_addr_i, OFS_IO_DATA);
  assign wr_dir      = reg_hit(reg_wr_i, reg_addr_i, OFS_IO_DIRECTION);
  assign wr_opt      = reg_hit(reg_wr_i, reg_addr_i, OFS_CONFIG_OPT);
  assign wdata_p     = reg_wdata_i[PINS-1:0];
  assign data_access = (wop != WOP_NONE) || rd_data;

  // Next direction and option, so pads and pull-ups follow a write at once
  assign dir_d    = wr_dir ? wdata_p : dir_q;
  assign option_d = wr_opt ? reg_wdata_i : option_q;

  ////////////////////////////////////////////////////////////////////////////
  // Port registers

  // Output latch: set and clear writes sample pins, modify, store all bits; a data write loads as written
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= RST_LATCH;
    end else begin
      latch_q <= rmw_apply(wop, pin_i, wdata_p, latch_q);
    end
  end

  // Direction register, one bit per pin
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= RST_DIRECTION[PINS-1:0];
    end else if (wr_dir) begin
      dir_q <= wdata_p;
    end
  end

  // Option register; only the pull-up bit is used here
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      option_q <= RST_OPTION;
    end else if (wr_opt) begin
      option_q <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Read data stand for the one cycle after the strobe
  // Aliases and unmapped offsets read as zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= RST_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_IO_DATA:      rdata_q <= to_reg(pin_i);
        OFS_IO_DIRECTION: rdata_q <= to_reg(dir_q);
        OFS_CONFIG_OPT:   rdata_q <= option_q;
        OFS_IRQ_CONTROL:  rdata_q <= irqc.status;
        OFS_IRQ_MASK:     rdata_q <= irqc.mask;
        default:          rdata_q <= RST_ZERO;
      endcase
    end else begin
      rdata_q <= RST_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  // Driven value: a copy of the latch, updated at the same edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_q <= RST_LATCH[PINS-1:0];
    end else begin
      pin_out_q <= rmw_apply(wop, pin_i, wdata_p, latch_q);
    end
  end

  // Enable low drives the latch, high floats the pin
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_n_q <= RST_DIRECTION[PINS-1:0];
    end else begin
      oe_n_q <= dir_d;
    end
  end

  // Pull-ups: global active-low enable, never on an output pin; they take
  // the next direction so a pin never drives against its own pull-up
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pullup_q <= RST_ZERO[PINS-1:0];
    end else begin
      pullup_q <= {PINS{~option_d[OPT_PULLUP_N_BIT]}} & dir_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternate functions

  // Schmitt input buffer on pins serving an alternate function
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      schmitt_q <= RST_ZERO[PINS-1:0];
    end else begin
      schmitt_q                <= RST_ZERO[PINS-1:0];
      schmitt_q[EXT_IRQ_PIN]   <= ext_irq_mode_i;
      schmitt_q[PROG_CLK_PIN]  <= prog_mode_i;
      schmitt_q[PROG_DATA_PIN] <= prog_mode_i;
    end
  end

  // External interrupt tap on pin zero; its edge logic lives elsewhere
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_irq_q <= 1'b0;
    end else begin
      ext_irq_q <= pin_i[EXT_IRQ_PIN];
    end
  end

  // Programming clock tap, quiet outside programming mode
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_clk_q <= 1'b0;
    end else begin
      prog_clk_q <= prog_mode_i & pin_i[PROG_CLK_PIN];
    end
  end

  // Programming data tap, quiet outside programming mode
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_data_q <= 1'b0;
    end else begin
      prog_data_q <= prog_mode_i & pin_i[PROG_DATA_PIN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change detection and interrupt

  // First cycle after reset takes the reference without a false change,
  // even though the pins may have moved while reset was held
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // Upper nibble and its direction bits go to the detector
  assign chg.pins    = pin_i[CHG_LO_PIN +: CHG_W];
  assign chg.dir     = dir_q[CHG_LO_PIN +: CHG_W];
  assign chg.refresh = data_access | init_q;

  // Change detector against the last-access reference
  bpc_change_det u_change_det (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .chg       (chg.det)
  );

  // Mismatch keeps setting the flag; W1C clear at irq_control
  assign irqc.event_set = chg.mismatch;
  assign irqc.wr_ctl    = reg_hit(reg_wr_i, reg_addr_i, OFS_IRQ_CONTROL);
  assign irqc.wr_mask   = reg_hit(reg_wr_i, reg_addr_i, OFS_IRQ_MASK);
  assign irqc.wdata     = reg_wdata_i;

  // Sticky flag, enable mask and level interrupt
  bpc_irq_reg u_irq_reg (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .irqc      (irqc.irq_reg)
  );

  // Wake request while asleep and a change is flagged
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleep_i & irqc.status[IRQ_CHANGE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Register port
  assign reg_rdata_o    = rdata_q;

  // Pads
  assign pin_o          = pin_out_q;
  assign pin_oe_n_o     = oe_n_q;
  assign pullup_en_o    = pullup_q;
  assign schmitt_sel_o  = schmitt_q;

  // Alternate functions
  assign pin0_ext_irq_o = ext_irq_q;
  assign prog_clk_o     = prog_clk_q;
  assign prog_data_o    = prog_data_q;

  // Events
  assign wake_o         = wake_q;
  assign irq_o          = irqc.irq;

endmodule

//--- testbench/bpc_port_props.sv
/*
  Port checker for the bidirectional port.
  Assumes it is bound to bpc_port_top and sees only its ports.
*/
`timescale 1ns/100ps
module bpc_port_props
  import bpc_pkg::*;
#(
  parameter int unsigned PINS = 8
)
(
  // Clock and reset
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Pins and modes
  input wire logic [PINS-1:0]   pin_i,
  input wire logic [PINS-1:0]   pin_o,
  input wire logic [PINS-1:0]   pin_oe_n_o,
  input wire logic [PINS-1:0]   pullup_en_o,
  input wire logic [PINS-1:0]   schmitt_sel_o,
  input wire logic              sleep_i,
  input wire logic              ext_irq_mode_i,
  input wire logic              prog_mode_i,
  // Alternate functions and events
  input wire logic              pin0_ext_irq_o,
  input wire logic              prog_clk_o,
  input wire logic              prog_data_o,
  input wire logic              wake_o,
  input wire logic              irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////
  // Bus and pin events
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  // Upper input pin moves in a cycle with no port access, while asleep
  sequence s_change;
    !reg_rd_i && !reg_wr_i && sleep_i && $past(rst_n_i) && $stable(pin_oe_n_o)
      && (((pin_i[7:4] ^ $past(pin_i[7:4])) & pin_oe_n_o[7:4]) != 4'h0);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_read_pins: assert property (s_rd(OFS_IO_DATA) |=> reg_rdata_o == $past(pin_i))
    else $error("data read not pin levels");
  a_dir_oe: assert property (s_wr(OFS_IO_DIRECTION) |=> pin_oe_n_o == $past(reg_wdata_i))
    else $error("enable not direction");
  a_latch_load: assert property (s_wr(OFS_IO_DATA) |=> pin_o == $past(reg_wdata_i))
    else $error("latch not loaded");
  a_set_alias: assert property (s_wr(OFS_IO_SET) |=>
    pin_o == ($past(pin_i) | $past(reg_wdata_i)))
    else $error("set not from pins");
  a_clr_alias: assert property (s_wr(OFS_IO_CLR) |=>
    pin_o == ($past(pin_i) & ~$past(reg_wdata_i)))
    else $error("clear not from pins");
  a_pullup_output: assert property ((pullup_en_o & ~pin_oe_n_o) == 8'h00)
    else $error("pull-up on output");
  a_change_wake: assert property (s_change |->
    ##[1:5] (wake_o || !sleep_i || reg_wr_i || reg_rd_i))
    else $error("change did not wake");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i))
    else $error("wake while awake");
  a_schmitt_sel: assert property (1'b1 |=> schmitt_sel_o ==
    {{2{$past(prog_mode_i)}}, 5'h00, $past(ext_irq_mode_i)})
    else $error("input buffer select wrong");
  a_ext_copy: assert property (1'b1 |=> pin0_ext_irq_o == $past(pin_i[0]))
    else $error("pin zero copy wrong");
endmodule

//--- testbench/bpc_pin_model.sv
/*
  Board model of the eight pads: device drive, board drive, weak pull-up.
  Assumes board drive values change only after a clock edge.
*/
`timescale 1ns/100ps
module bpc_pin_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Device side
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_n_i,
  input  wire logic [7:0] pullup_i,
  // Board side
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_drv_i,
  output logic      [7:0] level_o
);
  logic [7:0] last_q = 8'h00;

  // Remembers the level so a floating pad can wander
  always_ff @(posedge ref_clk_i) begin
    last_q <= level_o;
  end

  // Device drive wins, then board drive, then pull-up, else no stable level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n_i[i]) begin
        level_o[i] = pad_out_i[i];
      end else if (ext_drv_i[i]) begin
        level_o[i] = ext_val_i[i];
      end else if (pullup_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = ~last_q[i];
      end
    end
  end
endmodule

//--- testbench/bidir_port_change_irq_test.sv
/*
  Self-checking bench for the bidirectional port with change interrupt.
  Assumes bpc_pkg, the design files and the pin model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module bidir_port_change_irq_test;
  import bpc_pkg::*;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, ext_val = 8'h00, ext_drv = 8'hFF;
  logic [7:0] rdata, pin_i, pin_o, oe_n, pu, sch;
  logic       wr = 1'b0, rd = 1'b0, sleep = 1'b0, eim = 1'b0, pm = 1'b0;
  logic       x0, pclk, pdat, wake, irq;
  int         n_fail = 0, comparisons = 0, cycles = 0, seed = 32'he5cf;

  always #20 ref_clk_i = ~ref_clk_i;

  bpc_port_top #(.PINS(8)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(oe_n), .pullup_en_o(pu), .schmitt_sel_o(sch), .sleep_i(sleep),
    .ext_irq_mode_i(eim), .prog_mode_i(pm), .pin0_ext_irq_o(x0), .prog_clk_o(pclk),
    .prog_data_o(pdat), .wake_o(wake), .irq_o(irq));

  bpc_pin_model pads_u (.ref_clk_i(ref_clk_i), .pad_out_i(pin_o), .pad_oe_n_i(oe_n),
    .pullup_i(pu), .ext_val_i(ext_val), .ext_drv_i(ext_drv), .level_o(pin_i));

  ////////////////////////////////////////////////////////////////////////
  // Bus tasks and expectations
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    #1;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Pin level with the board driving every input pin
  function automatic logic [7:0] f_pins(input logic [7:0] d, input logic [7:0] l,
                                        input logic [7:0] e);
    return (~d & l) | (d & e);
  endfunction
  task automatic summarize;
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, l, e, v, p;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk_rd(OFS_IO_DIRECTION, RST_DIRECTION);
    chk_rd(OFS_CONFIG_OPT, RST_OPTION);
    `CHK(pu, 8'h00)
    `CHK(oe_n, 8'hFF)
    chk_rd(8'h55, 8'h00);
    // Random direction, latch and board levels, then set and clear aliases
    repeat (8) begin
      {d, l, e, v} = $random(seed);
      ext_val <= e;
      wr_reg(OFS_IO_DIRECTION, d);
      wr_reg(OFS_IO_DATA, l);
      wr_reg(OFS_CONFIG_OPT, {e[0], 7'h7F});
      idle(2);
      `CHK(oe_n, d)
      `CHK(pin_o, l)
      `CHK(pu, {8{~e[0]}} & d)
      chk_rd(OFS_IO_DATA, f_pins(d, l, e));
      p = f_pins(d, l, e) | v;
      wr_reg(OFS_IO_SET, v);
      `CHK(pin_o, p)
      wr_reg(OFS_IO_CLR, v);
      `CHK(pin_o, f_pins(d, p, e) & ~v)
    end
    // Released pins rise through the pull-ups
    ext_drv <= 8'h00;
    wr_reg(OFS_IO_DIRECTION, 8'hFF);
    wr_reg(OFS_CONFIG_OPT, 8'h7F);
    idle(3);
    chk_rd(OFS_IO_DATA, 8'hFF);
    // Change detection on the upper input pins
    ext_val <= 8'h00;
    ext_drv <= 8'hFF;
    wr_reg(OFS_CONFIG_OPT, 8'hFF);
    idle(2);
    chk_rd(OFS_IO_DATA, 8'h00);
    wr_reg(OFS_IRQ_CONTROL, 8'h01);
    chk_rd(OFS_IRQ_CONTROL, 8'h00);
    ext_val <= 8'h0F;
    idle(5);
    chk_rd(OFS_IRQ_CONTROL, 8'h00);
    ext_val <= 8'h8F;
    sleep <= 1'b1;
    idle(5);
    `CHK(irq, 1'b0)
    `CHK(wake, 1'b1)
    chk_rd(OFS_IRQ_CONTROL, 8'h01);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    idle(2);
    `CHK(irq, 1'b1)
    wr_reg(OFS_IRQ_CONTROL, 8'h01);
    chk_rd(OFS_IRQ_CONTROL, 8'h01);
    chk_rd(OFS_IO_DATA, 8'h8F);
    wr_reg(OFS_IRQ_CONTROL, 8'h01);
    chk_rd(OFS_IRQ_CONTROL, 8'h00);
    idle(2);
    `CHK(irq, 1'b0)
    // Upper pin turned output and driven low is left out of the compare
    wr_reg(OFS_IO_DATA, 8'h00);
    wr_reg(OFS_IO_DIRECTION, 8'h7F);
    idle(5);
    chk_rd(OFS_IRQ_CONTROL, 8'h00);
    // Alternate pin functions and input buffer selection
    wr_reg(OFS_IO_DIRECTION, 8'hFF);
    eim <= 1'b1;
    pm <= 1'b1;
    ext_val <= 8'hC1;
    idle(3);
    `CHK(sch, 8'hC1)
    `CHK(x0, 1'b1)
    `CHK({pdat, pclk}, 2'h3)
    summarize();
  end
endmodule

bind bpc_port_top bpc_port_props #(.PINS(PINS)) props_u (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
  .pullup_en_o(pullup_en_o), .schmitt_sel_o(schmitt_sel_o), .sleep_i(sleep_i),
  .ext_irq_mode_i(ext_irq_mode_i), .prog_mode_i(prog_mode_i),
  .pin0_ext_irq_o(pin0_ext_irq_o), .prog_clk_o(prog_clk_o), .prog_data_o(prog_data_o),
  .wake_o(wake_o), .irq_o(irq_o));
